/* sfpfe_pkg.sv */
package sfpfe_pkg;

	// lane width codes of one transfer unit
	localparam logic [1:0] WIDTH_1 = 2'h0;
	localparam logic [1:0] WIDTH_2 = 2'h1;
	localparam logic [1:0] WIDTH_4 = 2'h2;

	// bits moved per clock for each width
	localparam logic [3:0] BITS_1 = 4'h1;
	localparam logic [3:0] BITS_2 = 4'h2;
	localparam logic [3:0] BITS_4 = 4'h4;

	// lanes driven for each width; single lane output is lane1
	localparam logic [3:0] MASK_1 = 4'h2;
	localparam logic [3:0] MASK_2 = 4'h3;
	localparam logic [3:0] MASK_4 = 4'hF;

	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_FULL = 4'h8;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] LANES_OFF = 4'h0;

	typedef enum logic [1:0] {
		UNIT_RECV = 2'b01,
		UNIT_DRIVE = 2'b10
	} sfpfe_unit_t;

	typedef struct packed {
		logic drive;
		logic [1:0] width;
		logic [7:0] data;
	} sfpfe_cmd_t;

	typedef struct packed {
		logic quad_lane_enable;
		logic pause_or_reset_select;
		logic reset_pin_disable;
		logic four_lane_instruction_mode;
	} sfpfe_cfg_t;

	typedef struct packed {
		logic lane3;
		logic lane2;
		logic lane1;
		logic lane0;
	} sfpfe_lanes_t;

	function automatic logic [3:0] lane_bits(input logic [1:0] width);
		lane_bits = (width == WIDTH_4) ? BITS_4 : (width == WIDTH_2) ? BITS_2 : BITS_1;
	endfunction

	function automatic logic [3:0] lane_mask(input logic [1:0] width);
		lane_mask = (width == WIDTH_4) ? MASK_4 : (width == WIDTH_2) ? MASK_2 : MASK_1;
	endfunction

endpackage

/* sfpfe_sync.sv */
`timescale 1ns/10ps
module sfpfe_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2,
	parameter bit ASYNC_RST = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [STAGES*WIDTH-1:0] chain;

	initial begin
		if (STAGES < 2 || WIDTH < 1) begin
			$error("sfpfe_sync needs at least two stages and one bit");
		end
	end

	// only the last stage is read outside the chain
	assign q = chain[STAGES*WIDTH-1 -: WIDTH];

	generate
		if (ASYNC_RST) begin : g_async
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					chain <= '0;
				end else begin
					chain <= {chain[(STAGES-1)*WIDTH-1:0], d};
				end
			end
		end else begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					chain <= '0;
				end else begin
					chain <= {chain[(STAGES-1)*WIDTH-1:0], d};
				end
			end
		end
	endgenerate

endmodule

/* sfpfe_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RQ1 - reset pin high: normal operation, instructions accepted.
// RQ2 - reset pin low: reset mode, every lane output floats.
// RQ3 - host avoids reset during internal write, program or erase.
// RQ4 - function config bit 0 set ignores dedicated reset pin, clear honours it.
// RQ5 - quad off, dedicated reset disabled: fourth pin pause if select 0, reset if 1.
// RQ6 - only clock modes 0 and 3, both accepted without configuration.
// RQ7 - host parks clock low in mode 0, high in mode 3.
// RQ8 - all incoming bits sampled on serial clock rising edge.
// RQ9 - output data changes on serial clock falling edge.
// RQ10 - dual units turn lanes 0 and 1 bidirectional, direction per phase.
// RQ11 - quad or four-lane mode turn lanes 0 to 3 bidirectional.
// RQ12 - chip enable high: deselected, outputs float, input ignored.
// RQ13 - host drives chip enable high to low before first instruction.
// RQ14 - quad enable set: write protect and pause/reset functions unavailable.
// RQ15 - pause low while selected: freeze sequence, float output, resume on high.
// RQ16 - reset abandons partial instruction, serial logic idles for next select; code restarts a frame on the next rising edge while still selected.
module sfpfe_top #(
	parameter int SYNC_STAGES = 2
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic SCK,
	input wire logic CE_N,
	input wire logic RESET_N,
	input sfpfe_pkg::sfpfe_lanes_t LANE_I,
	output sfpfe_pkg::sfpfe_lanes_t LANE_O,
	output sfpfe_pkg::sfpfe_lanes_t LANE_OE,
	input sfpfe_pkg::sfpfe_cfg_t CFG,
	input sfpfe_pkg::sfpfe_cmd_t CMD,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	output logic [7:0] RX_DATA,
	output logic RX_VALID,
	output logic IN_RESET,
	output logic WRITE_PROTECT_N
);

	initial begin
		if (SYNC_STAGES < 2) begin
			$error("sfpfe_top needs at least two synchroniser stages");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state carriers

	typedef struct packed {
		logic rst_q;
		logic reset_active;
		logic hold_en;
		logic wp_n;
		logic pending;
		sfpfe_pkg::sfpfe_cmd_t cmd;
		logic req_tog;
		logic rx_seen;
		logic [7:0] rx_data;
		logic rx_valid;
	} sfpfe_sys_t;

	typedef struct packed {
		logic started;
		sfpfe_pkg::sfpfe_unit_t unit;
		logic [1:0] width;
		logic [7:0] shift;
		logic [3:0] cnt;
		logic hold;
	} sfpfe_frame_t;

	typedef struct packed {
		logic ack_tog;
		logic rx_tog;
		logic [7:0] rx_byte;
	} sfpfe_xfer_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} sfpfe_fall_t;

	sfpfe_sys_t sys;
	sfpfe_sys_t next_sys;
	sfpfe_frame_t frame;
	sfpfe_frame_t next_frame;
	sfpfe_xfer_t xfer;
	sfpfe_xfer_t next_xfer;
	sfpfe_fall_t fall;
	sfpfe_fall_t next_fall;

	logic [2:0] pins_s;
	logic [1:0] link_tog_s;
	logic [1:0] cfg_s;
	logic req_s;
	logic frame_clr;
	logic [3:0] lanes_in;

	assign lanes_in = {LANE_I.lane3, LANE_I.lane2, LANE_I.lane1, LANE_I.lane0};

	////////////////////////////////////////////////////////////////////////////////
	// crossings

	// asynchronous pins into the system domain
	sfpfe_sync #(.WIDTH(3), .STAGES(SYNC_STAGES), .ASYNC_RST(1'b0)) u_sync_pins (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.d({RESET_N, LANE_I.lane3, LANE_I.lane2}),
		.q(pins_s)
	);

	// link toggles into the system domain
	sfpfe_sync #(.WIDTH(2), .STAGES(SYNC_STAGES), .ASYNC_RST(1'b0)) u_sync_tog (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.d({xfer.ack_tog, xfer.rx_tog}),
		.q(link_tog_s)
	);

	// configuration levels into the link domain
	sfpfe_sync #(.WIDTH(2), .STAGES(SYNC_STAGES), .ASYNC_RST(1'b1)) u_sync_cfg (
		.clk(SCK),
		.rst(sys.reset_active),
		.d({sys.hold_en, CFG.four_lane_instruction_mode}),
		.q(cfg_s)
	);

	// command request toggle into the link domain
	sfpfe_sync #(.WIDTH(1), .STAGES(SYNC_STAGES), .ASYNC_RST(1'b1)) u_sync_req (
		.clk(SCK),
		.rst(sys.rst_q),
		.d(sys.req_tog),
		.q(req_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// system domain: reset selection, pin roles, command and receive hand-off

	always_comb begin
		logic ded_rst;
		logic shr_rst;
		ded_rst = 1'b0;
		shr_rst = 1'b0;
		next_sys = sys;
		next_sys.rst_q = 1'b0;
		next_sys.rx_valid = 1'b0;
		ded_rst = ~CFG.reset_pin_disable & ~pins_s[2]; // RQ4
		shr_rst = ~CFG.quad_lane_enable & CFG.reset_pin_disable
			& CFG.pause_or_reset_select & ~pins_s[1]; // RQ5
		next_sys.reset_active = ded_rst | shr_rst; // RQ1
		next_sys.hold_en = ~CFG.quad_lane_enable
			& ~(CFG.reset_pin_disable & CFG.pause_or_reset_select); // RQ14
		next_sys.wp_n = CFG.quad_lane_enable ? 1'b1 : pins_s[0]; // RQ14
		if (sys.pending && link_tog_s[1] == sys.req_tog) begin
			next_sys.pending = 1'b0;
		end
		if (CMD_VALID && CMD_READY) begin
			next_sys.pending = 1'b1;
			next_sys.cmd = CMD;
			next_sys.req_tog = ~sys.req_tog;
		end
		if (link_tog_s[0] != sys.rx_seen) begin
			next_sys.rx_seen = link_tog_s[0];
			next_sys.rx_data = xfer.rx_byte;
			next_sys.rx_valid = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			sys <= '{
				rst_q: 1'b1,
				reset_active: 1'b1,
				hold_en: 1'b0,
				wp_n: 1'b1,
				pending: 1'b0,
				cmd: '0,
				req_tog: 1'b0,
				rx_seen: 1'b0,
				rx_data: sfpfe_pkg::BYTE_ZERO,
				rx_valid: 1'b0
			};
		end else begin
			sys <= next_sys;
		end
	end

	// no new command while the device sits in reset
	assign CMD_READY = ~sys.pending & ~sys.reset_active;
	assign RX_DATA = sys.rx_data;
	assign RX_VALID = sys.rx_valid;
	assign IN_RESET = sys.reset_active;
	assign WRITE_PROTECT_N = sys.wp_n;

	////////////////////////////////////////////////////////////////////////////////
	// link domain, rising edge: sampling and unit sequencing

	// frame ends on deselect or on reset
	assign frame_clr = CE_N | sys.reset_active; // RQ12 RQ16

	always_comb begin
		logic [3:0] step;
		logic [7:0] shifted;
		logic [3:0] cnt_next;
		logic [1:0] width;
		width = frame.width;
		// first unit of a frame takes its width from the mode at its first edge
		if (!frame.started) begin
			width = cfg_s[0] ? sfpfe_pkg::WIDTH_4 : sfpfe_pkg::WIDTH_1; // RQ11
		end
		step = sfpfe_pkg::lane_bits(width);
		shifted = frame.shift;
		cnt_next = frame.cnt + step;
		next_frame = frame;
		next_xfer = xfer;
		next_frame.width = width;
		next_frame.hold = cfg_s[1] & ~LANE_I.lane3; // RQ15
		if (!frame.started) begin
			next_frame.started = 1'b1;
			// a command left over from before this frame is dropped
			next_xfer.ack_tog = req_s;
		end
		if (!next_frame.hold) begin
			unique case (width)
				sfpfe_pkg::WIDTH_4: shifted = {frame.shift[3:0], lanes_in}; // RQ11
				sfpfe_pkg::WIDTH_2: shifted = {frame.shift[5:0], lanes_in[1:0]}; // RQ10
				default: shifted = {frame.shift[6:0], lanes_in[0]}; // RQ8
			endcase
			next_frame.shift = shifted;
			next_frame.cnt = cnt_next;
			if (cnt_next >= sfpfe_pkg::CNT_FULL) begin
				next_frame.cnt = sfpfe_pkg::CNT_ZERO;
				if (frame.unit == sfpfe_pkg::UNIT_RECV) begin
					next_xfer.rx_byte = shifted;
					next_xfer.rx_tog = ~xfer.rx_tog;
				end
				if (frame.started && req_s != xfer.ack_tog) begin
					next_xfer.ack_tog = req_s;
					next_frame.unit = sys.cmd.drive ? sfpfe_pkg::UNIT_DRIVE
						: sfpfe_pkg::UNIT_RECV; // RQ10
					next_frame.width = sys.cmd.width;
					next_frame.shift = sys.cmd.data;
				end else begin
					next_frame.unit = sfpfe_pkg::UNIT_RECV;
					next_frame.width = cfg_s[0] ? sfpfe_pkg::WIDTH_4
						: sfpfe_pkg::WIDTH_1; // RQ11
					next_frame.shift = sfpfe_pkg::BYTE_ZERO;
				end
			end
		end
	end

	// either idle clock level works: only edges inside the frame are used
	always_ff @(posedge SCK or posedge frame_clr) begin // RQ6 RQ8
		if (frame_clr) begin
			frame <= '{
				started: 1'b0,
				unit: sfpfe_pkg::UNIT_RECV,
				width: sfpfe_pkg::WIDTH_1,
				shift: sfpfe_pkg::BYTE_ZERO,
				cnt: sfpfe_pkg::CNT_ZERO,
				hold: 1'b0
			};
		end else begin
			frame <= next_frame;
		end
	end

	always_ff @(posedge SCK or posedge sys.rst_q) begin
		if (sys.rst_q) begin
			xfer <= '{
				ack_tog: 1'b0,
				rx_tog: 1'b0,
				rx_byte: sfpfe_pkg::BYTE_ZERO
			};
		end else if (!frame_clr) begin
			xfer <= next_xfer;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// link domain, falling edge: output launch

	always_comb begin
		next_fall.out = sfpfe_pkg::LANES_OFF;
		next_fall.oe = sfpfe_pkg::LANES_OFF;
		unique case (frame.width)
			sfpfe_pkg::WIDTH_4: next_fall.out = frame.shift[7:4];
			sfpfe_pkg::WIDTH_2: next_fall.out = {2'h0, frame.shift[7:6]};
			default: next_fall.out = {2'h0, frame.shift[7], 1'b0};
		endcase
		if (frame.unit == sfpfe_pkg::UNIT_DRIVE && !frame.hold) begin // RQ15
			next_fall.oe = sfpfe_pkg::lane_mask(frame.width); // RQ10 RQ11
		end
	end

	always_ff @(negedge SCK or posedge frame_clr) begin // RQ9
		if (frame_clr) begin
			fall <= '{out: sfpfe_pkg::LANES_OFF, oe: sfpfe_pkg::LANES_OFF}; // RQ2 RQ12
		end else begin
			fall <= next_fall;
		end
	end

	assign LANE_O = fall.out;
	assign LANE_OE = fall.oe;

endmodule

/* sfpfe_checker.sv */
`timescale 1ns/10ps
module sfpfe_checker (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic SCK,
	input wire logic CE_N,
	input wire logic RESET_N,
	input sfpfe_pkg::sfpfe_lanes_t LANE_I,
	input sfpfe_pkg::sfpfe_lanes_t LANE_O,
	input sfpfe_pkg::sfpfe_lanes_t LANE_OE,
	input sfpfe_pkg::sfpfe_cfg_t CFG,
	input wire logic CMD_VALID,
	input wire logic CMD_READY,
	input wire logic RX_VALID,
	input wire logic IN_RESET,
	input wire logic WRITE_PROTECT_N
);
	logic [7:0] at_rise;
	always_ff @(posedge SCK) at_rise <= {LANE_O, LANE_OE};
	sequence pin_low;
		(!RESET_N && !CFG.reset_pin_disable) [*4];
	endsequence
	sequence shared_low;
		(!CFG.quad_lane_enable && CFG.reset_pin_disable && CFG.pause_or_reset_select
			&& !LANE_I.lane3) [*4];
	endsequence
	a_pin_reset_enter: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		pin_low |-> IN_RESET) else $error("reset pin not honoured");
	a_shared_reset: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		shared_low |-> IN_RESET) else $error("shared pin reset not honoured");
	a_pin_ignored: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(CFG.reset_pin_disable && !CFG.pause_or_reset_select) [*4] |-> !IN_RESET)
		else $error("disabled reset pin acted");
	a_reset_float: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		IN_RESET [*2] |-> LANE_OE == 4'h0) else $error("lane driven in reset");
	a_deselect_float: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		CE_N [*2] |-> LANE_OE == 4'h0) else $error("lane driven while deselected");
	a_quad_wp: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		CFG.quad_lane_enable [*2] |-> WRITE_PROTECT_N) else $error("protect active in quad");
	a_cmd_taken: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		CMD_VALID && CMD_READY |=> !CMD_READY) else $error("command not taken");
	a_rx_pulse: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		RX_VALID |=> !RX_VALID) else $error("receive strobe too long");
	a_launch_fall: assert property (@(negedge SCK) disable iff (SYS_RST || CE_N || IN_RESET)
		{LANE_O, LANE_OE} == at_rise) else $error("output moved in clock high phase");
endmodule

/* sfpfe_host.sv */
`timescale 1ns/10ps
module sfpfe_host (
	output logic SCK,
	output logic CE_N,
	output sfpfe_pkg::sfpfe_lanes_t LANE_I,
	input sfpfe_pkg::sfpfe_lanes_t LANE_O,
	input sfpfe_pkg::sfpfe_lanes_t LANE_OE
);
	logic [3:0] hv = 4'hC;
	logic [3:0] he = 4'hC;
	logic [3:0] li;
	logic junk = 1'b0;
	logic cpol = 1'b0;
	initial begin
		SCK = 1'b0;
		CE_N = 1'b1;
	end
	always @(SCK) junk <= ~junk;
	// released lanes show a changing pattern
	assign li = (LANE_OE & LANE_O) | (~LANE_OE & ((he & hv) | (~he & ({4{junk}} ^ 4'h5))));
	assign LANE_I = sfpfe_pkg::sfpfe_lanes_t'(li);
	task automatic sel(input logic pol);
		cpol = pol;
		SCK = pol;
		// a shared clock may run while deselected; it settles the mode flops
		repeat (3) begin
			#32 SCK = ~pol;
			#32 SCK = pol;
		end
		#40 CE_N = 1'b0;
	endtask
	task automatic desel();
		#32 SCK = cpol;
		#8 CE_N = 1'b1;
		he = 4'hC;
		hv = 4'hC;
		#40;
	endtask
	task automatic xfer(input logic [7:0] d, input logic [1:0] w, input logic drv,
		output logic [7:0] q);
		int n;
		logic [3:0] m;
		n = (w == 2'h2) ? 4 : (w == 2'h1) ? 2 : 1;
		m = (n == 4) ? 4'hF : (n == 2) ? 4'h3 : 4'h1;
		for (int k = 0; k < 8; k += n) begin
			SCK = 1'b0;
			he = drv ? (4'hF & ~((n == 1) ? 4'h2 : m)) : (4'hC | m);
			for (int j = 0; j < n; j++) hv[j] = d[8 - k - n + j];
			#32 SCK = 1'b1;
			for (int j = 0; j < n; j++) q[8 - k - n + j] = (n == 1 && drv) ? li[1] : li[j];
			#32;
		end
	endtask
endmodule

/* sfpfe_tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module sfpfe_tb_top;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reset_n = 1'b1;
	logic cmd_valid = 1'b0;
	sfpfe_pkg::sfpfe_cfg_t cfg = '0;
	sfpfe_pkg::sfpfe_cmd_t cmd = '0;
	sfpfe_pkg::sfpfe_lanes_t lane_i, lane_o, lane_oe;
	logic sck, ce_n, cmd_ready, rx_valid, in_reset, write_protect_n;
	logic [7:0] rx_data, last_rx, q;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	always #2 sys_clk = ~sys_clk;
	sfpfe_top dut_u (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .SCK(sck), .CE_N(ce_n),
		.RESET_N(reset_n), .LANE_I(lane_i), .LANE_O(lane_o), .LANE_OE(lane_oe), .CFG(cfg),
		.CMD(cmd), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .RX_DATA(rx_data),
		.RX_VALID(rx_valid), .IN_RESET(in_reset), .WRITE_PROTECT_N(write_protect_n));
	sfpfe_host host_u (.SCK(sck), .CE_N(ce_n), .LANE_I(lane_i), .LANE_O(lane_o), .LANE_OE(lane_oe));
	always @(posedge sys_clk) begin
		cyc++;
		if (rx_valid === 1'b1) last_rx <= rx_data;
		if (cyc == 30000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic send_cmd(input logic [1:0] w, input logic [7:0] d);
		@(posedge sys_clk);
		for (int i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(posedge sys_clk);
		cmd <= '{1'b1, w, d};
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic frame(input logic pol, input logic [1:0] w, input logic [7:0] d,
		input logic [7:0] o);
		host_u.sel(pol);
		fork
			host_u.xfer(d, 2'h0, 1'b0, q);
			begin
				#100;
				send_cmd(w, o);
			end
		join
		host_u.xfer(8'h00, w, 1'b1, q);
		host_u.desel();
		cyc_wait(4);
		`CHK(last_rx, d)
		`CHK(q, o)
	endtask
	task automatic pin(input logic v);
		@(posedge sys_clk) reset_n <= v;
		cyc_wait(5);
	endtask
	task automatic s_reset_pins();
		host_u.hv[2] = 1'b0;
		cyc_wait(5);
		`CHK(write_protect_n, 1'b0)
		cfg.quad_lane_enable <= 1'b1;
		cyc_wait(5);
		`CHK(write_protect_n, 1'b1)
		host_u.hv[2] = 1'b1;
		cfg <= '0;
		pin(1'b0);
		`CHK(in_reset, 1'b1)
		`CHK(lane_oe, 4'h0)
		`CHK(cmd_ready, 1'b0)
		cfg.reset_pin_disable <= 1'b1;
		cyc_wait(5);
		`CHK(in_reset, 1'b0)
		host_u.hv[3] = 1'b0;
		cfg.pause_or_reset_select <= 1'b1;
		cyc_wait(5);
		`CHK(in_reset, 1'b1)
		host_u.hv[3] = 1'b1;
		cfg <= '0;
		pin(1'b1);
		`CHK(in_reset, 1'b0)
	endtask
	task automatic s_abort();
		host_u.sel(1'b0);
		host_u.xfer(8'hFF, 2'h1, 1'b0, q);
		pin(1'b0);
		pin(1'b1);
		host_u.xfer(8'h5A, 2'h0, 1'b0, q);
		host_u.desel();
		cyc_wait(4);
		`CHK(last_rx, 8'h5A)
	endtask
	task automatic s_four_lane();
		cfg.four_lane_instruction_mode <= 1'b1;
		host_u.sel(1'b0);
		host_u.xfer(8'hD2, 2'h2, 1'b0, q);
		host_u.desel();
		cyc_wait(4);
		`CHK(last_rx, 8'hD2)
		cfg <= '0;
	endtask
	task automatic s_pause();
		host_u.sel(1'b0);
		// rises with the pause pin low must not count
		host_u.hv[3] = 1'b0;
		host_u.xfer(8'hFF, 2'h1, 1'b0, q);
		host_u.hv[3] = 1'b1;
		host_u.xfer(8'h96, 2'h0, 1'b0, q);
		host_u.desel();
		cyc_wait(4);
		`CHK(last_rx, 8'h96)
	endtask
	initial begin
		cyc_wait(3);
		sys_rst <= 1'b0;
		cyc_wait(4);
		frame(1'b0, 2'h0, 8'hA5, 8'hC3);
		frame(1'b1, 2'h0, 8'h3C, 8'h81);
		cfg.quad_lane_enable <= 1'b1;
		frame(1'b0, 2'h1, 8'h69, 8'hB4);
		frame(1'b0, 2'h2, 8'h1E, 8'hE7);
		s_four_lane();
		s_reset_pins();
		s_abort();
		s_pause();
		wrap_up();
	end
endmodule
bind sfpfe_top sfpfe_checker chk_u (.SYS_CLK, .SYS_RST, .SCK, .CE_N, .RESET_N, .LANE_I, .LANE_O,
	.LANE_OE, .CFG, .CMD_VALID, .CMD_READY, .RX_VALID, .IN_RESET, .WRITE_PROTECT_N);
